/* File: shared/dpvd_pkg.sv */
// Package for the dual-panel video DMA block: register map, fields, reset values.
// Assumes a 32-bit classic Wishbone register bus and byte addressing.
package dpvd_pkg;
  localparam int ADR_W = 12;
  // Register byte offsets
  localparam logic [ADR_W-1:0] OFF_VIDEO_DMA_CONTROL = 12'h1e0;
  localparam logic [ADR_W-1:0] OFF_FRAME_BUFFER_START = 12'h1c0;
  localparam logic [ADR_W-1:0] OFF_FRAME_BUFFER_END = 12'h1c4;
  localparam logic [ADR_W-1:0] OFF_UPPER_PANEL_INIT_POINTER = 12'h1c8;
  localparam logic [ADR_W-1:0] OFF_LOWER_PANEL_INIT_POINTER = 12'h1cc;
  localparam logic [ADR_W-1:0] OFF_CURSOR_VERTICAL_START = 12'h1d0;
  localparam logic [ADR_W-1:0] OFF_CURSOR_VERTICAL_END = 12'h1d4;
  localparam logic [ADR_W-1:0] OFF_DISPLAY_VERTICAL_START = 12'h1d8;
  localparam logic [ADR_W-1:0] OFF_DISPLAY_VERTICAL_END = 12'h1dc;
  localparam logic [ADR_W-1:0] OFF_DMA_STATUS = 12'h1e4;
  localparam logic [ADR_W-1:0] OFF_LOWER_POINTER_STATUS = 12'h1e8;
  // Field positions
  localparam int CTL_DUAL_BIT = 7;
  localparam int CTL_ENABLE_BIT = 5;
  localparam int PTR_LAST_BIT = 30;
  localparam int CUR_MODE_LO = 13;
  localparam int RASTER_W = 11;
  // Values after reset
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Pointer step of one quad-word
  localparam logic [31:0] QW_STEP = 32'h0000_0010;
  // Cursor placement codes
  localparam logic [1:0] CUR_INACTIVE = 2'h0;
  localparam logic [1:0] CUR_UPPER = 2'h1;
  localparam logic [1:0] CUR_LOWER = 2'h2;
  localparam logic [1:0] CUR_STRADDLE = 2'h3;
  typedef enum logic [1:0] {DPVD_IDLE, DPVD_FETCH_UPPER, DPVD_FETCH_LOWER} dpvd_state_type;
endpackage

/* File: rtl/dpvd_video_dma.sv */
// Dual-panel video DMA: Wishbone registers, paired quad-word fetch, cursor placement.
// Assumes the video macrocell, memory port and raster count share clk_i.
`timescale 1ns/1ps
// Summary of operation
// - First quad-word of a pair feeds upper half, second the lower half.
// - Block sequences paired fetches; start, end, init programmed as single panel.
// - Cursor start bits 14:13: inactive, upper, lower, straddling; code 0 still places the cursor in the upper half.
// - Normally start and end hold raster counts of cursor first and last line.
// - Straddling: start counts lower panel to end, end counts top to start.
// - Straddling cursor shows lower from display start, upper up to display end.
// - In dual mode quad-word fetches always come as back-to-back pairs.
// - Bit 7 of video DMA control at 0x1e0 selects dual-panel DMA.
// - Each dual service fetches one quad-word per panel, half a buffer apart.
// - Every fetch is a quad-word; pointers advance by 0x10.
module dpvd_video_dma (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dpvd_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Macrocell video side
  input wire logic frame_sync_i,
  input wire logic video_req_i,
  input wire logic [dpvd_pkg::RASTER_W-1:0] raster_i,
  output logic [127:0] qw_data_o,
  output logic qw_valid_o,
  output logic qw_lower_o,
  output logic cursor_upper_o,
  output logic cursor_lower_o,
  // Memory fetch port
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [127:0] mem_rdata_i
);
  import dpvd_pkg::*;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Wrap at the buffer end or when the last flag is set, otherwise step one quad-word
  function automatic logic [31:0] next_ptr(input logic [31:0] p, input logic [31:0] s,
                                           input logic [31:0] e);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (p[PTR_LAST_BIT] || (p[29:4] == e[29:4])) begin
      r[29:4] = s[29:4];
    end else begin
      r = {2'h0, p[29:0]} + QW_STEP;
      r[31:30] = 2'h0;
    end
    return r;
  endfunction

  function automatic logic in_span(input logic [RASTER_W-1:0] r, input logic [RASTER_W-1:0] lo,
                                   input logic [RASTER_W-1:0] hi);
    return (r >= lo) && (r <= hi);
  endfunction

  // Register file
  logic [7:0] ctl_q, ctl_d;
  logic [31:0] fb_start_q, fb_start_d, fb_end_q, fb_end_d;
  logic [31:0] init_up_q, init_up_d, init_lo_q, init_lo_d;
  logic [31:0] cvs_q, cvs_d, cve_q, cve_d, dvs_q, dvs_d, dve_q, dve_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  // DMA state
  dpvd_state_type state_q, state_d;
  logic [31:0] ptr_up_q, ptr_up_d, ptr_lo_q, ptr_lo_d;
  logic req_q, req_d;
  logic [31:0] addr_q, addr_d;
  logic [127:0] qw_q, qw_d;
  logic qv_q, qv_d, ql_q, ql_d;
  // Cursor state
  logic cu_q, cu_d, cl_q, cl_d;

  logic bus_hit, dual, wr;
  assign bus_hit = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = bus_hit && wb_we_i;
  assign dual = ctl_q[CTL_DUAL_BIT];

  always_comb begin
    ctl_d = ctl_q;
    fb_start_d = fb_start_q;
    fb_end_d = fb_end_q;
    init_up_d = init_up_q;
    init_lo_d = init_lo_q;
    cvs_d = cvs_q;
    cve_d = cve_q;
    dvs_d = dvs_q;
    dve_d = dve_q;
    ack_d = bus_hit;
    rdat_d = 32'h0000_0000;
    if (wr) begin
      unique case (wb_adr_i)
        OFF_VIDEO_DMA_CONTROL: if (wb_sel_i[0]) ctl_d = wb_dat_i[7:0];
        OFF_FRAME_BUFFER_START: fb_start_d = merge_bytes(fb_start_q, wb_dat_i, wb_sel_i);
        OFF_FRAME_BUFFER_END: fb_end_d = merge_bytes(fb_end_q, wb_dat_i, wb_sel_i);
        OFF_UPPER_PANEL_INIT_POINTER: init_up_d = merge_bytes(init_up_q, wb_dat_i, wb_sel_i);
        OFF_LOWER_PANEL_INIT_POINTER: init_lo_d = merge_bytes(init_lo_q, wb_dat_i, wb_sel_i);
        OFF_CURSOR_VERTICAL_START: cvs_d = merge_bytes(cvs_q, wb_dat_i, wb_sel_i);
        OFF_CURSOR_VERTICAL_END: cve_d = merge_bytes(cve_q, wb_dat_i, wb_sel_i);
        OFF_DISPLAY_VERTICAL_START: dvs_d = merge_bytes(dvs_q, wb_dat_i, wb_sel_i);
        OFF_DISPLAY_VERTICAL_END: dve_d = merge_bytes(dve_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end else if (bus_hit) begin
      // Cursor and display vertical registers are write-only and read as zero
      unique case (wb_adr_i)
        OFF_VIDEO_DMA_CONTROL: rdat_d = {24'h000000, ctl_q};
        OFF_FRAME_BUFFER_START: rdat_d = fb_start_q;
        OFF_FRAME_BUFFER_END: rdat_d = fb_end_q;
        OFF_UPPER_PANEL_INIT_POINTER: rdat_d = init_up_q;
        OFF_LOWER_PANEL_INIT_POINTER: rdat_d = init_lo_q;
        OFF_DMA_STATUS: rdat_d = ptr_up_q | {30'h0, state_q};
        OFF_LOWER_POINTER_STATUS: rdat_d = ptr_lo_q;
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= CTL_RESET;
      fb_start_q <= REG_RESET;
      fb_end_q <= REG_RESET;
      init_up_q <= REG_RESET;
      init_lo_q <= REG_RESET;
      cvs_q <= REG_RESET;
      cve_q <= REG_RESET;
      dvs_q <= REG_RESET;
      dve_q <= REG_RESET;
      ack_q <= 1'b0;
      rdat_q <= REG_RESET;
    end else if (ce_i) begin
      ctl_q <= ctl_d;
      fb_start_q <= fb_start_d;
      fb_end_q <= fb_end_d;
      init_up_q <= init_up_d;
      init_lo_q <= init_lo_d;
      cvs_q <= cvs_d;
      cve_q <= cve_d;
      dvs_q <= dvs_d;
      dve_q <= dve_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Paired fetch sequencer; frame sync only reloads between services
  always_comb begin
    state_d = state_q;
    ptr_up_d = ptr_up_q;
    ptr_lo_d = ptr_lo_q;
    req_d = req_q;
    addr_d = addr_q;
    qw_d = qw_q;
    qv_d = 1'b0;
    ql_d = ql_q;
    unique case (state_q)
      DPVD_IDLE: begin
        if (frame_sync_i) begin
          ptr_up_d = init_up_q;
          ptr_lo_d = init_lo_q;
        end else if (video_req_i && ctl_q[CTL_ENABLE_BIT]) begin
          state_d = DPVD_FETCH_UPPER;
          req_d = 1'b1;
          addr_d = {2'h0, ptr_up_q[29:4], 4'h0};
        end
      end
      DPVD_FETCH_UPPER: begin
        if (mem_ack_i) begin
          qw_d = mem_rdata_i;
          qv_d = 1'b1;
          ql_d = 1'b0;
          ptr_up_d = next_ptr(ptr_up_q, fb_start_q, fb_end_q);
          if (dual) begin
            state_d = DPVD_FETCH_LOWER;
            addr_d = {2'h0, ptr_lo_q[29:4], 4'h0};
          end else begin
            state_d = DPVD_IDLE;
            req_d = 1'b0;
          end
        end
      end
      DPVD_FETCH_LOWER: begin
        if (mem_ack_i) begin
          qw_d = mem_rdata_i;
          qv_d = 1'b1;
          ql_d = 1'b1;
          ptr_lo_d = next_ptr(ptr_lo_q, fb_start_q, fb_end_q);
          state_d = DPVD_IDLE;
          req_d = 1'b0;
        end
      end
      default: begin
        state_d = DPVD_IDLE;
        req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DPVD_IDLE;
      ptr_up_q <= REG_RESET;
      ptr_lo_q <= REG_RESET;
      req_q <= 1'b0;
      addr_q <= REG_RESET;
      qw_q <= '0;
      qv_q <= 1'b0;
      ql_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      ptr_up_q <= ptr_up_d;
      ptr_lo_q <= ptr_lo_d;
      req_q <= req_d;
      addr_q <= addr_d;
      qw_q <= qw_d;
      qv_q <= qv_d;
      ql_q <= ql_d;
    end
  end

  // Cursor placement against the current raster
  logic [1:0] cur_mode;
  logic [RASTER_W-1:0] cvs_r, cve_r, dvs_r, dve_r;
  assign cur_mode = cvs_q[CUR_MODE_LO +: 2];
  assign cvs_r = cvs_q[RASTER_W-1:0];
  assign cve_r = cve_q[RASTER_W-1:0];
  assign dvs_r = dvs_q[RASTER_W-1:0];
  assign dve_r = dve_q[RASTER_W-1:0];

  always_comb begin
    cu_d = 1'b0;
    cl_d = 1'b0;
    unique case (cur_mode)
      CUR_INACTIVE: cu_d = in_span(raster_i, cvs_r, cve_r);
      CUR_UPPER: cu_d = in_span(raster_i, cvs_r, cve_r);
      CUR_LOWER: cl_d = in_span(raster_i, cvs_r, cve_r);
      CUR_STRADDLE: begin
        // Lower half is scanned from its top, so start marks the cursor end there
        cl_d = in_span(raster_i, dvs_r, cvs_r);
        cu_d = in_span(raster_i, cve_r, dve_r);
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cu_q <= 1'b0;
      cl_q <= 1'b0;
    end else if (ce_i) begin
      cu_q <= cu_d;
      cl_q <= cl_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign mem_req_o = req_q;
  assign mem_addr_o = addr_q;
  assign qw_data_o = qw_q;
  assign qw_valid_o = qv_q;
  assign qw_lower_o = ql_q;
  assign cursor_upper_o = cu_q;
  assign cursor_lower_o = cl_q;

  // Checks; stalled cycles are excluded since ce_i freezes all state
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence upper_done_s;
    state_q == DPVD_FETCH_UPPER && mem_ack_i && dual;
  endsequence
  sequence lower_fetch_s;
    state_q == DPVD_FETCH_LOWER && req_q;
  endsequence

  dual_reset_a: assert property ($past(rst_i) |-> !ctl_q[CTL_DUAL_BIT])
    else $error("dual-panel bit not clear after reset");
  ctl_write_a: assert property (wr && wb_sel_i[0] && wb_adr_i == OFF_VIDEO_DMA_CONTROL
    |=> ctl_q == $past(wb_dat_i[7:0]))
    else $error("control write not stored");
  pair_order_a: assert property (upper_done_s |=> lower_fetch_s)
    else $error("lower fetch did not follow upper fetch");
  single_fetch_a: assert property (state_q == DPVD_FETCH_UPPER && mem_ack_i && !dual
    |=> state_q == DPVD_IDLE && !req_q)
    else $error("single mode issued a second fetch");
  lower_tag_a: assert property (qv_q && ql_q |-> $past(state_q) == DPVD_FETCH_LOWER)
    else $error("lower panel data tagged wrongly");
  step_size_a: assert property (state_q == DPVD_FETCH_UPPER && mem_ack_i
    && !ptr_up_q[PTR_LAST_BIT] && ptr_up_q[29:4] != fb_end_q[29:4]
    |=> ptr_up_q == $past({2'h0, ptr_up_q[29:0]}) + QW_STEP)
    else $error("pointer did not step by one quad-word");
  qw_align_a: assert property (req_q |-> addr_q[3:0] == 4'h0)
    else $error("fetch address not quad-word aligned");
  straddle_low_a: assert property (cur_mode == CUR_STRADDLE && in_span(raster_i, dvs_r, cvs_r)
    |=> cl_q)
    else $error("straddling cursor missing in lower half");
  upper_only_a: assert property (cur_mode == CUR_UPPER |=> !cl_q)
    else $error("upper-half cursor shown in lower half");
  ack_pulse_a: assert property (ack_q |=> !ack_q)
    else $error("bus acknowledge held too long");
endmodule // dpvd_video_dma

/* File: bench/dpvd_mem_model.sv */
// Memory partner for the fetch port: answers each request after a set lag.
// Assumes the requester holds req and address until it sees ack.
`timescale 1ns/1ps
module dpvd_mem_model (
  // Clock and answer lag
  input wire logic clk_i,
  input wire logic [3:0] lag_i,
  // Fetch port
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [127:0] mem_rdata_o
);
  logic [3:0] wait_q;
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = '0;
    wait_q = 4'h0;
  end
  // Data names its address; between answers it flips, so a stale capture shows
  always @(posedge clk_i) begin
    if (mem_ack_o || !mem_req_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      wait_q <= 4'h0;
    end else if (wait_q == lag_i) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= {4{mem_addr_i}};
    end else begin
      wait_q <= wait_q + 4'h1;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule // dpvd_mem_model

/* File: bench/dpvd_video_dma_test.sv */
// Self-checking bench: registers, paired fetches, cursor placement.
// Assumes the memory partner model and a Wishbone master written here.
`timescale 1ns/1ps
module dpvd_video_dma_test;
  import dpvd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sync = 1'b0, vreq = 1'b0, ce = 1'b1;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0, lag = 4'h0;
  logic [31:0] wdat = '0, dat_o, maddr;
  logic ack, qv, ql, cu, cl, mreq, mack;
  logic [RASTER_W-1:0] rast = '0;
  logic [127:0] qd, mdat;
  int n_mismatch = 0, comparisons = 0, cycles = 0;

  always #25 clk = ~clk;

  dpvd_video_dma i_dut (
    .clk_i(clk), .rst_i(rst), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .frame_sync_i(sync), .video_req_i(vreq), .raster_i(rast),
    .qw_data_o(qd), .qw_valid_o(qv), .qw_lower_o(ql),
    .cursor_upper_o(cu), .cursor_lower_o(cl),
    .mem_req_o(mreq), .mem_addr_o(maddr), .mem_ack_i(mack), .mem_rdata_i(mdat)
  );

  dpvd_mem_model i_mem (
    .clk_i(clk), .lag_i(lag), .mem_req_i(mreq), .mem_addr_i(maddr),
    .mem_ack_o(mack), .mem_rdata_o(mdat)
  );

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Waits on ack with no assumed latency; only the cycle ceiling ends it
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [ADR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic wait_qv();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (qv !== 1'b1 && n < 40);
    check(qv, 1'b1);
  endtask

  task automatic pulse_sync();
    @(posedge clk);
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
  endtask

  // One service: upper word first, then in dual mode the lower one in the same request
  task automatic svc(input logic [31:0] up, input logic [31:0] lo, input logic dual);
    @(posedge clk);
    vreq <= 1'b1;
    @(posedge clk);
    vreq <= 1'b0;
    wait_qv();
    check(ql, 1'b0);
    check(qd, {4{up}});
    if (dual) begin
      check(mreq, 1'b1);
      check(maddr, lo);
      wait_qv();
      check(ql, 1'b1);
      check(qd, {4{lo}});
    end
    check(mreq, 1'b0);
  endtask

  task automatic t_regs();
    rdchk(OFF_VIDEO_DMA_CONTROL, {24'h0, CTL_RESET});
    rdchk(OFF_LOWER_POINTER_STATUS, REG_RESET);
    wr(OFF_CURSOR_VERTICAL_START, 32'h0000_6014);
    rdchk(OFF_CURSOR_VERTICAL_START, 32'h0);
    wr(12'h100, 32'hffff_ffff);
    rdchk(12'h100, 32'h0);
    wr(OFF_VIDEO_DMA_CONTROL, 32'h0000_005a);
    rdchk(OFF_VIDEO_DMA_CONTROL, 32'h0000_005a);
  endtask

  // Buffer programmed as one panel; lower pointer half a buffer on
  task automatic t_fetch();
    wr(OFF_FRAME_BUFFER_START, 32'h0000_1000);
    wr(OFF_FRAME_BUFFER_END, 32'h0000_1030);
    wr(OFF_UPPER_PANEL_INIT_POINTER, 32'h0000_1000);
    wr(OFF_LOWER_PANEL_INIT_POINTER, 32'h0000_1020);
    wr(OFF_VIDEO_DMA_CONTROL, 32'h0000_0020);
    pulse_sync();
    svc(32'h0000_1000, 32'h0, 1'b0);
    svc(32'h0000_1010, 32'h0, 1'b0);
    // Macrocell taken as already set for LCD duplex driving
    wr(OFF_VIDEO_DMA_CONTROL, 32'h0000_00a0);
    pulse_sync();
    lag <= 4'h3;
    svc(32'h0000_1000, 32'h0000_1020, 1'b1);
    lag <= 4'h0;
    svc(32'h0000_1010, 32'h0000_1030, 1'b1);
    svc(32'h0000_1020, 32'h0000_1000, 1'b1);
    // Lower init sits on the buffer end, so only its last flag is set
    wr(OFF_UPPER_PANEL_INIT_POINTER, 32'h0000_1010);
    wr(OFF_LOWER_PANEL_INIT_POINTER, 32'h4000_1030);
    pulse_sync();
    svc(32'h0000_1010, 32'h0000_1030, 1'b1);
    svc(32'h0000_1020, 32'h0000_1000, 1'b1);
    rdchk(OFF_DMA_STATUS, 32'h0000_1030);
    rdchk(OFF_LOWER_POINTER_STATUS, 32'h0000_1010);
  endtask

  // Entries: placement code, raster, expected upper and lower
  task automatic t_cursor();
    logic [14:0] tab [8];
    tab = '{{CUR_INACTIVE, 11'd20, 2'b10}, {CUR_UPPER, 11'd41, 2'b00},
            {CUR_UPPER, 11'd40, 2'b10}, {CUR_LOWER, 11'd30, 2'b01},
            {CUR_STRADDLE, 11'd15, 2'b01}, {CUR_STRADDLE, 11'd50, 2'b10},
            {CUR_STRADDLE, 11'd30, 2'b00}, {CUR_STRADDLE, 11'd101, 2'b00}};
    wr(OFF_DISPLAY_VERTICAL_START, 32'd10);
    wr(OFF_DISPLAY_VERTICAL_END, 32'd100);
    wr(OFF_CURSOR_VERTICAL_END, 32'd40);
    foreach (tab[i]) begin
      wr(OFF_CURSOR_VERTICAL_START, {17'h0, tab[i][14:13], 13'd20});
      rast <= tab[i][12:2];
      repeat (2) @(posedge clk);
      check({cu, cl}, tab[i][1:0]);
    end
  endtask

  // Mid-run reset must drop dual mode again
  task automatic t_rerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFF_VIDEO_DMA_CONTROL, {24'h0, CTL_RESET});
    rdchk(OFF_DMA_STATUS, REG_RESET);
  endtask

  // Enable low freezes the bus answer; the held write lands once it returns
  task automatic t_stall();
    @(posedge clk);
    ce <= 1'b0;
    fork
      wr(OFF_FRAME_BUFFER_START, 32'h0000_2000);
      begin
        repeat (4) @(posedge clk);
        check(ack, 1'b0);
        ce <= 1'b1;
      end
    join
    rdchk(OFF_FRAME_BUFFER_START, 32'h0000_2000);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fetch();
    t_rerst();
    t_cursor();
    t_stall();
    conclude();
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch++;
      conclude();
    end
  end
endmodule // dpvd_video_dma_test
